// ==== pkg/skx_consts.vh ====
// Purpose: constants for the security key exchange message framer
// Assumes: one clock, classic Wishbone register access, 32-bit data
// Notes:   byte offsets on the bus; one message byte per word in the buffer windows
`ifndef SKX_CONSTS_VH
`define SKX_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SKX_REG_CTRL        12'h000
`define SKX_REG_CAPS        12'h004
`define SKX_REG_STATUS      12'h008
`define SKX_REG_FLAGS       12'h00c
`define SKX_REG_STATE       12'h010
`define SKX_REG_SELECT      12'h014
`define SKX_REG_COOKIE      12'h020
`define SKX_REG_NEWCOOKIE   12'h040
`define SKX_TXMEM_BASE      12'h100
`define SKX_RXMEM_BASE      12'h400

// ****************************************************************
// reset values and field layouts
// ****************************************************************
`define SKX_CAPS_RST        32'h01030101
`define SKX_CTRL_AUTO_SO    1
`define SKX_CTRL_SEND_MAIN  0
`define SKX_ST_MAIN_SEEN    0
`define SKX_ST_QUICK_SEEN   1
`define SKX_ST_SIGNON_SEEN  2
`define SKX_ST_CONFIRMED    3
`define SKX_ST_PENDING      4
`define SKX_ST_TX_BUSY      5

// ****************************************************************
// class field masks: defined bits per class byte
// ****************************************************************
`define SKX_PKA_MASK        8'h01
`define SKX_HASH_MASK       8'h01
`define SKX_ENC_MASK        8'h03
`define SKX_NONCE_MASK      8'h01

// ****************************************************************
// request flag bit positions
// ****************************************************************
`define SKX_FL_FIRST        3
`define SKX_FL_RENEW        2
`define SKX_FL_BUMP         1
`define SKX_FL_SLOT         0

// ****************************************************************
// message kinds on the receive side
// ****************************************************************
`define SKX_RX_SIGNON       2'h0
`define SKX_RX_MAIN         2'h1
`define SKX_RX_QUICK        2'h2
`define SKX_RX_CONFIRM      2'h3

// ****************************************************************
// field sizes and message lengths in bytes, cookie size in 32-bit words
// ****************************************************************
`define SKX_PKA_BYTES       64
`define SKX_HASH_BYTES      20
`define SKX_NONCE_BYTES     8
`define SKX_HDR_BYTES       6
`define SKX_SIGNON_LEN      8
`define SKX_MAIN_REQ_LEN    206
`define SKX_QUICK_REQ_LEN   14
`define SKX_MAIN_RSP_LEN    98
`define SKX_RXMEM_DEPTH     200
`define SKX_TXMEM_DEPTH     92
`define SKX_COOKIE_WORDS    5

`endif

// ==== rtl/skx_class_pick.v ====
// Purpose: pick one offered option of an algorithm class
// Assumes: offered and supported bits already aligned to the class byte
// Notes:   highest common bit wins, so the stronger cipher is preferred
`timescale 1ns/1ps

module skx_class_pick
(
  input  wire [7:0] offered_i,    // class byte from the control centre
  input  wire [7:0] supported_i,  // terminal capability mask for this class
  output reg  [7:0] choice_o      // one-hot choice or all zeros
);

  // ****************************************************************
  // priority pick
  // ****************************************************************
  reg     [7:0] common;
  integer       i;

  always @*
  begin
    common   = offered_i & supported_i;
    choice_o = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (common[i])
      begin
        choice_o = 8'h01 << i;
      end
    end
  end

endmodule // skx_class_pick

// ==== rtl/security_key_exchange_msgs.v ====
// Purpose: terminal-side framer and parser for security handshake messages
// Assumes: bytes arrive most significant first; software does the key math
// Notes:   response payload and new cookie come from software over the bus
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "skx_consts.vh"

module security_key_exchange_msgs
(
  input  wire        clk_i,        // system clock, 200 MHz
  input  wire        rst_i,        // synchronous reset, active high
  input  wire        wb_cyc_i,     // wishbone cycle
  input  wire        wb_stb_i,     // wishbone strobe
  input  wire        wb_we_i,      // wishbone write enable
  input  wire [11:0] wb_adr_i,     // wishbone byte address
  input  wire [3:0]  wb_sel_i,     // wishbone byte selects
  input  wire [31:0] wb_dat_i,     // wishbone write data
  output reg  [31:0] wb_dat_o,     // wishbone read data
  output reg         wb_ack_o,     // wishbone acknowledge
  input  wire        rx_valid_i,   // receive byte valid
  input  wire        rx_sop_i,     // first byte of a message
  input  wire [1:0]  rx_kind_i,    // message kind, sampled with rx_sop_i
  input  wire [7:0]  rx_byte_i,    // receive byte
  output wire        rx_ready_o,   // receive byte accepted
  output reg         tx_valid_o,   // transmit byte valid
  output reg  [7:0]  tx_byte_o,    // transmit byte
  output reg         tx_last_o,    // last byte of the message
  output reg         tx_main_o,    // message is a main response, else sign-on response
  input  wire        tx_ready_i,   // transmit byte taken
  output reg         key_slot_o,   // session key slot to load
  output reg         key_apply_o,  // pulse: key for key_slot_o is being negotiated
  output reg         nv_commit_o   // pulse: persistent state just committed
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [2:0] TX_IDLE = 3'b001;
  localparam [2:0] TX_SO   = 3'b010;
  localparam [2:0] TX_MAIN = 3'b100;

  reg  [31:0] caps;
  reg         auto_so;
  reg  [5:0]  status_seen;
  reg  [7:0]  last_flags;
  reg  [31:0] offered;
  reg  [7:0]  cnt;
  reg         cnt_seq;
  reg         ck_seq;
  reg  [7:0]  pend_cnt;
  reg         pend_cnt_seq;
  reg         pend_ck_seq;
  reg         pend_ck_new;
  reg         pending;
  reg  [31:0] cookie     [0:`SKX_COOKIE_WORDS-1];
  reg  [31:0] new_cookie [0:`SKX_COOKIE_WORDS-1];
  reg  [7:0]  rx_mem     [0:`SKX_RXMEM_DEPTH-1];
  reg  [7:0]  tx_mem     [0:`SKX_TXMEM_DEPTH-1];
  reg  [1:0]  rx_kind;
  reg  [7:0]  rx_idx;
  reg  [2:0]  tx_state;
  reg  [7:0]  tx_idx;
  reg  [7:0]  tx_len;
  reg  [7:0]  cur_byte;
  reg         send_main;
  reg         send_so;

  wire [31:0] chosen;
  wire [31:0] class_mask = {`SKX_NONCE_MASK, `SKX_ENC_MASK, `SKX_HASH_MASK, `SKX_PKA_MASK};
  wire        tx_busy    = ~tx_state[0] | tx_valid_o;
  wire        rx_take    = rx_valid_i & rx_ready_o;
  wire [1:0]  kind_now   = rx_sop_i ? rx_kind_i : rx_kind;
  wire [7:0]  idx_now    = rx_sop_i ? 8'h00 : rx_idx;
  wire        wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [9:0]  wadr       = wb_adr_i[11:2];
  wire        in_tx      = wb_adr_i >= `SKX_TXMEM_BASE && wb_adr_i < `SKX_TXMEM_BASE + 4 * `SKX_TXMEM_DEPTH;
  wire        in_rx      = wb_adr_i >= `SKX_RXMEM_BASE && wb_adr_i < `SKX_RXMEM_BASE + 4 * `SKX_RXMEM_DEPTH;
  wire        in_ck      = wb_adr_i >= `SKX_REG_COOKIE && wb_adr_i < `SKX_REG_COOKIE + 4 * `SKX_COOKIE_WORDS;
  wire        in_nck     = wb_adr_i >= `SKX_REG_NEWCOOKIE && wb_adr_i < `SKX_REG_NEWCOOKIE + 4 * `SKX_COOKIE_WORDS;
  wire [11:0] tx_off     = wb_adr_i - `SKX_TXMEM_BASE;
  wire [11:0] rx_off     = wb_adr_i - `SKX_RXMEM_BASE;
  wire [11:0] ck_off     = wb_adr_i - `SKX_REG_COOKIE;
  wire [11:0] nck_off    = wb_adr_i - `SKX_REG_NEWCOOKIE;
  wire [31:0] wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign rx_ready_o = ~tx_busy | (kind_now != `SKX_RX_SIGNON);

  // ****************************************************************
  // one class picker per class byte
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_class
      skx_class_pick u_pick
      (
        .offered_i   (offered[8*g+7:8*g]),
        .supported_i (caps[8*g+7:8*g] & class_mask[8*g+7:8*g]),
        .choice_o    (chosen[8*g+7:8*g])
      );
    end
  endgenerate

  // ****************************************************************
  // receive parser and persistent state
  // ****************************************************************
  reg [7:0] base_cnt;
  reg       base_seq;
  integer   k;

  always @*
  begin
    // counter start point: zero when this main request renews the cookie
    base_cnt = (kind_now == `SKX_RX_MAIN && last_flags[`SKX_FL_RENEW]) ? 8'h00 : cnt;
    base_seq = (kind_now == `SKX_RX_MAIN && last_flags[`SKX_FL_RENEW]) ? 1'b0 : cnt_seq;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_kind      <= `SKX_RX_SIGNON;
      rx_idx       <= 8'h00;
      offered      <= 32'h00000000;
      last_flags   <= 8'h00;
      cnt          <= 8'h00;
      cnt_seq      <= 1'b0;
      ck_seq       <= 1'b0;
      pend_cnt     <= 8'h00;
      pend_cnt_seq <= 1'b0;
      pend_ck_seq  <= 1'b0;
      pend_ck_new  <= 1'b0;
      pending      <= 1'b0;
      key_slot_o   <= 1'b0;
      key_apply_o  <= 1'b0;
      nv_commit_o  <= 1'b0;
      send_so      <= 1'b0;
      status_seen  <= 6'h00;
      for (k = 0; k < `SKX_COOKIE_WORDS; k = k + 1)
      begin
        cookie[k] <= 32'h00000000;
      end
    end
    else
    begin
      key_apply_o <= 1'b0;
      nv_commit_o <= 1'b0;
      send_so     <= 1'b0;
      if (wb_req && wb_we_i && wadr == `SKX_REG_STATUS / 4)
      begin
        status_seen <= status_seen & ~wb_dat_i[5:0];
      end
      if (wb_req && wb_we_i && wadr == `SKX_REG_STATE / 4)
      begin
        cnt     <= wb_dat_i[7:0];
        cnt_seq <= wb_dat_i[8];
        ck_seq  <= wb_dat_i[9];
      end
      if (wb_req && wb_we_i && in_ck)
      begin
        cookie[ck_off[4:2]] <= (cookie[ck_off[4:2]] & ~wmask) | (wb_dat_i & wmask);
      end
      if (rx_take)
      begin
        rx_kind <= kind_now;
        rx_idx  <= idx_now + 8'h01;
        case (kind_now)
          `SKX_RX_SIGNON:
          begin
            if (idx_now < 8'h04)
            begin
              offered[8*idx_now[1:0] +: 8] <= rx_byte_i;
            end
            if (idx_now == `SKX_SIGNON_LEN - 1)
            begin
              status_seen[`SKX_ST_SIGNON_SEEN] <= 1'b1;
              send_so                          <= auto_so;
            end
          end
          `SKX_RX_MAIN, `SKX_RX_QUICK:
          begin
            // link identifier and reserved bits are not checked
            if (idx_now == 8'h04)
            begin
              last_flags <= rx_byte_i;
            end
            if (idx_now >= `SKX_HDR_BYTES && idx_now < `SKX_MAIN_REQ_LEN)
            begin
              rx_mem[idx_now - `SKX_HDR_BYTES] <= rx_byte_i;
            end
            if ((kind_now == `SKX_RX_MAIN && idx_now == `SKX_MAIN_REQ_LEN - 1) ||
                (kind_now == `SKX_RX_QUICK && idx_now == `SKX_QUICK_REQ_LEN - 1))
            begin
              key_slot_o  <= last_flags[`SKX_FL_SLOT];
              key_apply_o <= 1'b1;
              pending     <= 1'b1;
              pend_ck_new <= kind_now == `SKX_RX_MAIN && last_flags[`SKX_FL_RENEW];
              pend_ck_seq <= ck_seq ^ (kind_now == `SKX_RX_MAIN && last_flags[`SKX_FL_RENEW]);
              if (last_flags[`SKX_FL_BUMP])
              begin
                pend_cnt     <= base_cnt + 8'h01;
                pend_cnt_seq <= ~base_seq;
              end
              else
              begin
                pend_cnt     <= base_cnt;
                pend_cnt_seq <= base_seq;
              end
              if (kind_now == `SKX_RX_MAIN)
              begin
                status_seen[`SKX_ST_MAIN_SEEN] <= 1'b1;
              end
              else
              begin
                status_seen[`SKX_ST_QUICK_SEEN] <= 1'b1;
              end
            end
          end
          default:
          begin
            // connect confirm: first byte commits what is pending
            if (idx_now == 8'h00 && pending)
            begin
              cnt         <= pend_cnt;
              cnt_seq     <= pend_cnt_seq;
              ck_seq      <= pend_ck_seq;
              pending     <= 1'b0;
              nv_commit_o <= 1'b1;
              status_seen[`SKX_ST_CONFIRMED] <= 1'b1;
              for (k = 0; k < `SKX_COOKIE_WORDS; k = k + 1)
              begin
                if (pend_ck_new)
                begin
                  cookie[k] <= new_cookie[k];
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // transmit framer
  // ****************************************************************
  always @*
  begin
    cur_byte = 8'h00;
    if (tx_state[1])
    begin
      if (tx_idx < 8'h04)
      begin
        cur_byte = chosen[8*tx_idx[1:0] +: 8];
      end
    end
    else if (tx_state[2])
    begin
      if (tx_idx == 8'h04)
      begin
        cur_byte = {6'h00, ck_seq, pend_cnt_seq};
      end
      else if (tx_idx == 8'h05)
      begin
        cur_byte = pend_cnt;
      end
      else if (tx_idx >= `SKX_HDR_BYTES)
      begin
        cur_byte = tx_mem[tx_idx - `SKX_HDR_BYTES];
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state   <= TX_IDLE;
      tx_idx     <= 8'h00;
      tx_len     <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_byte_o  <= 8'h00;
      tx_last_o  <= 1'b0;
      tx_main_o  <= 1'b0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          if (tx_ready_i)
          begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
          end
          tx_idx <= 8'h00;
          if (send_so)
          begin
            tx_state  <= TX_SO;
            tx_len    <= 8'd`SKX_SIGNON_LEN;
            tx_main_o <= 1'b0;
          end
          else if (send_main)
          begin
            tx_state  <= TX_MAIN;
            tx_len    <= 8'd`SKX_MAIN_RSP_LEN;
            tx_main_o <= 1'b1;
          end
        end
        TX_SO, TX_MAIN:
        begin
          if (!tx_valid_o || tx_ready_i)
          begin
            tx_byte_o  <= cur_byte;
            tx_valid_o <= 1'b1;
            tx_last_o  <= tx_idx == tx_len - 8'h01;
            tx_idx     <= tx_idx + 8'h01;
            if (tx_idx == tx_len - 8'h01)
            begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      caps      <= `SKX_CAPS_RST;
      auto_so   <= 1'b1;
      send_main <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (tx_state[2])
      begin
        send_main <= 1'b0;
      end
      if (wb_req && wb_we_i)
      begin
        if (wadr == `SKX_REG_CTRL / 4 && wb_sel_i[0])
        begin
          auto_so <= wb_dat_i[`SKX_CTRL_AUTO_SO];
          if (wb_dat_i[`SKX_CTRL_SEND_MAIN])
          begin
            send_main <= 1'b1;
          end
        end
        if (wadr == `SKX_REG_CAPS / 4)
        begin
          caps <= (caps & ~wmask) | (wb_dat_i & wmask);
        end
        if (in_tx && wb_sel_i[0])
        begin
          tx_mem[tx_off[8:2]] <= wb_dat_i[7:0];
        end
        if (in_nck)
        begin
          new_cookie[nck_off[4:2]] <= (new_cookie[nck_off[4:2]] & ~wmask) | (wb_dat_i & wmask);
        end
      end
      if (wb_req)
      begin
        wb_dat_o <= 32'h00000000;
        if (wadr == `SKX_REG_CTRL / 4)
          wb_dat_o <= {30'h0, auto_so, send_main};
        else if (wadr == `SKX_REG_CAPS / 4)
          wb_dat_o <= caps;
        else if (wadr == `SKX_REG_STATUS / 4)
          wb_dat_o <= {26'h0, tx_busy | send_main, pending, status_seen[3:0]};
        else if (wadr == `SKX_REG_FLAGS / 4)
          wb_dat_o <= {24'h0, last_flags};
        else if (wadr == `SKX_REG_STATE / 4)
          wb_dat_o <= {6'h0, pend_ck_seq, pend_cnt_seq, pend_cnt, 6'h0, ck_seq, cnt_seq, cnt};
        else if (wadr == `SKX_REG_SELECT / 4)
          wb_dat_o <= chosen;
        else if (in_ck)
          wb_dat_o <= cookie[ck_off[4:2]];
        else if (in_nck)
          wb_dat_o <= new_cookie[nck_off[4:2]];
        else if (in_tx)
          wb_dat_o <= {24'h0, tx_mem[tx_off[8:2]]};
        else if (in_rx)
          wb_dat_o <= {24'h0, rx_mem[rx_off[9:2]]};
      end
    end
  end

endmodule // security_key_exchange_msgs

// ==== tb/skx_assertions.sv ====
// Purpose: port checks for the key exchange framer
// Assumes: one clock, synchronous reset
// Notes:   bound to the framer top
`timescale 1ns/1ps

module skx_checker
(
  input wire       clk_i,       // clock
  input wire       rst_i,       // reset
  input wire       wb_cyc_i,    // cycle
  input wire       wb_stb_i,    // strobe
  input wire       wb_ack_o,    // ack
  input wire       rx_valid_i,  // rx valid
  input wire       rx_sop_i,    // rx start
  input wire [1:0] rx_kind_i,   // rx kind
  input wire       rx_ready_o,  // rx ready
  input wire       tx_valid_o,  // tx valid
  input wire [7:0] tx_byte_o,   // tx byte
  input wire       tx_last_o,   // tx last
  input wire       tx_main_o,   // tx kind
  input wire       tx_ready_i,  // tx ready
  input wire       key_apply_o, // key pulse
  input wire       nv_commit_o  // commit pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire        so  = tx_valid_o && !tx_main_o;
  wire        mr  = tx_valid_o && tx_main_o;
  wire        cnf = rx_valid_i && rx_ready_o && rx_sop_i && rx_kind_i == 2'h3;
  logic [7:0] idx;  // bytes already taken in this message
  always @(posedge clk_i)
  begin
    if (rst_i || (tx_valid_o && tx_ready_i && tx_last_o))
      idx <= 8'h00;
    else if (tx_valid_o && tx_ready_i)
      idx <= idx + 8'h01;
  end
  // ********
  // checks
  // ********
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  a_class_onehot: assert property (so && idx < 8'h04 |-> $onehot0(tx_byte_o))
    else $error("class field not one hot");
  a_class_bits: assert property (so && idx < 8'h04 |-> (tx_byte_o & (idx == 8'h02 ? 8'hfc : 8'hfe)) == 8'h00)
    else $error("class reserved bit set");
  a_so_tail: assert property (so && idx > 8'h03 |-> tx_byte_o == 8'h00)
    else $error("reserved word not zero");
  a_link_zero: assert property (mr && idx < 8'h04 |-> tx_byte_o == 8'h00)
    else $error("link id not zero");
  a_rsp_flags: assert property (mr && idx == 8'h04 |-> tx_byte_o[7:2] == 6'h00)
    else $error("flag reserved bits set");
  a_last_place: assert property (tx_valid_o |-> tx_last_o == (idx == (tx_main_o ? 8'h61 : 8'h07)))
    else $error("last byte misplaced");
  a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
    else $error("tx byte changed while stalled");
  a_key_pulse: assert property (key_apply_o |=> !key_apply_o)
    else $error("key pulse too long");
  a_commit_cause: assert property (nv_commit_o |-> $past(cnf) || $past(cnf, 2))
    else $error("commit without confirm");
  c_signon: cover property (so && tx_last_o && tx_ready_i);
  c_main: cover property (mr && tx_last_o && tx_ready_i);
  c_commit: cover property (nv_commit_o);
endmodule // skx_checker

bind security_key_exchange_msgs skx_checker u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_valid_i(rx_valid_i), .rx_sop_i(rx_sop_i), .rx_kind_i(rx_kind_i), .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o), .tx_main_o(tx_main_o),
  .tx_ready_i(tx_ready_i), .key_apply_o(key_apply_o), .nv_commit_o(nv_commit_o)
);

// ==== tb/skx_centre_model.sv ====
// Purpose: control centre side: sends requests, drains responses
// Assumes: bytes move on rising edges only
// Notes:   slow makes the sink stall every other cycle
`timescale 1ns/1ps

module skx_centre_model
(
  input  wire       clk_i,      // clock
  input  wire       ready_i,    // framer takes rx byte
  input  wire       tx_valid_i, // framer byte valid
  input  wire [7:0] tx_byte_i,  // framer byte
  output reg        valid_o,    // rx byte valid
  output reg        sop_o,      // rx first byte
  output reg  [1:0] kind_o,     // rx kind
  output reg  [7:0] byte_o,     // rx byte
  output reg        take_o      // tx byte taken
);
  logic       slow = 1'b0;
  int         stalls = 0;  // bytes whose wait for ready ran out
  logic [7:0] got[$];
  initial
  begin
    valid_o = 1'b0;
    sop_o = 1'b0;
    kind_o = 2'h0;
    byte_o = 8'h5a;
    take_o = 1'b1;
  end
  always @(posedge clk_i)
  begin
    if (tx_valid_i && take_o)
      got.push_back(tx_byte_i);
    take_o <= slow ? !take_o : 1'b1;
  end
  // ********
  // requests: sign-on carries head in bytes 0-3, others zero link id, flags at byte 4, then counting bytes
  // ********
  task automatic send(input [1:0] kind, input int len, input [31:0] head);
    int i;
    int w;
    begin
      for (i = 0; i < len; i++)
      begin
        valid_o <= 1'b1;
        sop_o <= (i == 0);
        kind_o <= kind;
        byte_o <= kind == 2'h0 ? (i < 4 ? head[31-8*i -: 8] : 8'h00) : i == 4 ? head[7:0] : i < 6 ? 8'h00 : i[7:0];
        w = 0;
        @(negedge clk_i);
        while (!ready_i && w < 400)
        begin
          @(negedge clk_i);
          w++;
        end
        if (w == 400)
          stalls++;
        @(posedge clk_i);
      end
      valid_o <= 1'b0;
      sop_o <= 1'b0;
      byte_o <= ~byte_o;
    end
  endtask
endmodule // skx_centre_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the key exchange framer
// Assumes: the centre model feeds and drains the byte streams
// Notes:   registers reached over classic Wishbone
`timescale 1ns/1ps
`include "skx_consts.vh"

module tb;
  reg         clk_i    = 1'b0;
  reg         rst_i    = 1'b1;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         wb_we_i  = 1'b0;
  reg  [11:0] wb_adr_i = 12'h000;
  reg  [3:0]  wb_sel_i = 4'hf;
  reg  [31:0] wb_dat_i = 32'h00000000;
  reg  [31:0] rd;
  wire [31:0] wb_dat_o;
  wire [1:0]  rx_kind_i;
  wire [7:0]  rx_byte_i, tx_byte_o;
  wire        wb_ack_o, rx_valid_i, rx_sop_i, rx_ready_o, tx_valid_o, tx_last_o;
  wire        tx_main_o, tx_ready_i, key_slot_o, key_apply_o, nv_commit_o;
  int         n_fail = 0;
  int         checks = 0;

  always #2.5 clk_i = ~clk_i;

  security_key_exchange_msgs u_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_sop_i(rx_sop_i), .rx_kind_i(rx_kind_i), .rx_byte_i(rx_byte_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o),
    .tx_main_o(tx_main_o), .tx_ready_i(tx_ready_i), .key_slot_o(key_slot_o), .key_apply_o(key_apply_o),
    .nv_commit_o(nv_commit_o)
  );
  skx_centre_model u_ncc
  (
    .clk_i(clk_i), .ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .valid_o(rx_valid_i),
    .sop_o(rx_sop_i), .kind_o(rx_kind_i), .byte_o(rx_byte_i), .take_o(tx_ready_i)
  );

  // ********
  // shared tasks
  // ********
  task automatic conclude;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task automatic check(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks++;
      if (got !== exp)
      begin
        n_fail++;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic wb(input we, input [11:0] adr, input [31:0] wd, output [31:0] rdat);
    int k;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      k = 0;
      do
      begin
        @(posedge clk_i);
        k++;
      end
      while (wb_ack_o !== 1'b1 && k < 50);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k == 50)
      begin
        n_fail++;
        conclude();
      end
      @(posedge clk_i);
    end
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? key_apply_o : w == 1 ? nv_commit_o : tx_last_o && tx_valid_o && tx_ready_i;
  endfunction
  task automatic await(input int w);
    int k;
    begin
      k = 0;
      do
      begin
        @(posedge clk_i);
        k++;
      end
      while (sig(w) !== 1'b1 && k < 400);
      if (k == 400)
      begin
        n_fail++;
        conclude();
      end
      @(posedge clk_i);
    end
  endtask
  function automatic [31:0] w4(input int i);
    return {u_ncc.got[i], u_ncc.got[i+1], u_ncc.got[i+2], u_ncc.got[i+3]};
  endfunction

  // ********
  // scenarios
  // ********
  task automatic s_regs;
    begin
      wb(1'b0, `SKX_REG_CAPS, 32'h0, rd);
      check("caps", `SKX_CAPS_RST, rd);
      wb(1'b1, 12'h0f0, 32'hffffffff, rd);
      wb(1'b0, 12'h0f0, 32'h0, rd);
      check("unmapped", 32'h0, rd);
    end
  endtask
  task automatic s_signon;
    begin
      u_ncc.slow = 1'b1;
      u_ncc.got.delete();
      u_ncc.send(2'h0, `SKX_SIGNON_LEN, 32'h01010301);
      await(2);
      check("so size", 32'h8, 32'(u_ncc.got.size()));
      check("so classes", 32'h01010201, w4(0));
      check("so reserved", 32'h0, w4(4));
      wb(1'b1, `SKX_REG_CAPS, 32'h01030001, rd);
      u_ncc.got.delete();
      u_ncc.send(2'h0, `SKX_SIGNON_LEN, 32'h01010101);
      await(2);
      check("so no hash", 32'h01000101, w4(0));
      wb(1'b1, `SKX_REG_CAPS, `SKX_CAPS_RST, rd);
    end
  endtask
  task automatic s_main;
    begin
      wb(1'b1, `SKX_TXMEM_BASE, 32'h000000a5, rd);
      wb(1'b1, `SKX_REG_NEWCOOKIE, 32'hc0c0a1e5, rd);
      u_ncc.send(2'h1, `SKX_MAIN_REQ_LEN, 32'h0000000f);
      await(0);
      check("slot", 32'h1, {31'h0, key_slot_o});
      wb(1'b0, `SKX_REG_FLAGS, 32'h0, rd);
      check("flags", 32'h0000000f, rd);
      wb(1'b0, `SKX_RXMEM_BASE + 12'h020, 32'h0, rd);
      check("modulus", 32'h0000000e, rd);
      wb(1'b0, `SKX_REG_STATE, 32'h0, rd);
      check("pending", 32'h03010000, rd);
      u_ncc.got.delete();
      wb(1'b1, `SKX_REG_CTRL, 32'h00000003, rd);
      await(2);
      check("rsp size", 32'h62, 32'(u_ncc.got.size()));
      check("rsp id", 32'h0, w4(0));
      check("rsp head", 32'h000101a5, w4(3));
      fork
        u_ncc.send(2'h3, 6, 32'h0);
        await(1);
      join
      wb(1'b0, `SKX_REG_STATE, 32'h0, rd);
      check("committed", 32'h00000301, rd & 32'h000003ff);
      wb(1'b0, `SKX_REG_COOKIE, 32'h0, rd);
      check("cookie", 32'hc0c0a1e5, rd);
    end
  endtask
  task automatic s_quick;
    begin
      wb(1'b1, `SKX_REG_STATE, 32'h000002ff, rd);
      u_ncc.send(2'h2, `SKX_QUICK_REQ_LEN, 32'h00000002);
      await(0);
      check("slot", 32'h0, {31'h0, key_slot_o});
      wb(1'b0, `SKX_REG_STATE, 32'h0, rd);
      check("held", 32'h000002ff, rd & 32'h000003ff);
      fork
        u_ncc.send(2'h3, 6, 32'h0);
        await(1);
      join
      wb(1'b0, `SKX_REG_STATE, 32'h0, rd);
      check("wrapped", 32'h00000300, rd & 32'h000003ff);
    end
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs();
    s_signon();
    s_main();
    s_quick();
    check("rx stalls", 32'h0, u_ncc.stalls);
    conclude();
  end
endmodule // tb
